/* src/omad_map.svh */
`ifndef OMAD_MAP_SVH
`define OMAD_MAP_SVH

// Captured high address byte after reset
`define OMAD_HI_BYTE_RST   8'h00
// Bit forced high by the run-utility input
`define OMAD_FORCE_MSB     8'h80
// Field positions inside the captured high byte
`define OMAD_BLK_MSB       7
`define OMAD_BLK_LSB       4
`define OMAD_A11_BIT       3
`define OMAD_A10_BIT       2
// 1 KB segment codes inside a 4 KB block (A11:A10)
`define OMAD_SEG_0         2'h0
`define OMAD_SEG_1         2'h1
`define OMAD_SEG_2         2'h2
`define OMAD_SEG_3         2'h3
// Level on the shared socket pin when a 1 KB type is fitted
`define OMAD_CTL_1K_LEVEL  1'h1
// Reset value of every select and enable
`define OMAD_SEL_RST       1'h0

`endif

/* src/omad_pkg.sv */
package omad_pkg;

    // One block selection: one-of-four for A15:A14, one-of-four for A13:A12
    typedef struct packed {
        logic [3:0] top;   // Bit i set selects A15:A14 == i
        logic [3:0] next;  // Bit i set selects A13:A12 == i
    } omad_strap_t;

    // Fitted socket type; the all-zero setting is the 2 KB type
    typedef enum logic [1:0] {
        OMAD_ROM_2K,
        OMAD_ROM_MASK_1K,
        OMAD_ROM_EPROM_1K,
        OMAD_ROM_EPROM_1K_ALT
    } omad_rom_type_t;

    // Chip selects for the four ROM sockets
    typedef struct packed {
        logic a_low;
        logic a_high;
        logic b_low;
        logic b_high;
    } omad_sockets_t;

    // Decoded block selection
    typedef struct packed {
        logic       valid;
        logic [3:0] block;
    } omad_block_t;

endpackage : omad_pkg

/* src/omad_addr_latch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "omad_map.svh"

module omad_addr_latch (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr_bus,               // Multiplexed address lines
    input  wire logic       address_latch_pulse,    // Timing pulse, high early in cycle
    input  wire logic       run_utility_force,      // Forces the top address bit
    output logic      [7:0] hi_byte                 // Captured high byte, forced
);
    import omad_pkg::*;

    // Whole state of the latch
    typedef struct packed {
        logic       pulse_d;   // Pulse one cycle back
        logic [7:0] addr_d;    // Bus one cycle back
        logic [7:0] raw;       // Captured byte
        logic [7:0] out;       // Byte as presented
    } omad_latch_st_t;

    omad_latch_st_t st_ff;
    omad_latch_st_t nxt_st;

    // Capture on the falling edge of the pulse, using the byte seen while high
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.pulse_d = address_latch_pulse;
        nxt_st.addr_d  = addr_bus;
        if (st_ff.pulse_d && !address_latch_pulse) begin
            nxt_st.raw = st_ff.addr_d; // [RULE_14] [RULE_02]
        end
        // Force is a level and acts on the presented byte every cycle
        nxt_st.out = run_utility_force ? (nxt_st.raw | `OMAD_FORCE_MSB) : nxt_st.raw; // [RULE_01]
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{pulse_d: 1'h0, addr_d: `OMAD_HI_BYTE_RST,
                       raw: `OMAD_HI_BYTE_RST, out: `OMAD_HI_BYTE_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hi_byte = st_ff.out;

endmodule : omad_addr_latch
`default_nettype wire

/* src/omad_decoder.sv */
// Functional notes
// (RULE_01) Run-utility input forces top address bit high
// (RULE_02) Capture high address byte, decode chip selects
// (RULE_03) RAM selected when block matches RAM strap
// (RULE_04) RAM block enables buffers for whole 4 KB
// (RULE_05) Strap is one-of-four top plus one-of-four next
// (RULE_06) Two independent ROM pair block selectors
// (RULE_07) Shared block: RAM lowest, pair A low unused
// (RULE_08) 1 KB shared order: aL, bL, aH, bH
// (RULE_09) 2 KB: low socket lower half, high upper
// (RULE_10) 1 KB part in 2 KB socket wraps
// (RULE_11) Configurer fits one to four legal sockets
// (RULE_12) Type strap routes socket pins; default 2 KB
// (RULE_13) Buffers only on valid select; bad strap none
// (RULE_14) Latch high byte at pulse falling edge
// (RULE_15) Outputs gated by read strobe, not write absence
// (RULE_16) RAM decodes low ten bits, mirrors in block
`timescale 1ns/1ps
`default_nettype none
`include "omad_map.svh"

module omad_decoder (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic [7:0]              addr_bus,               // Multiplexed address lines
    input  wire logic                    address_latch_pulse,    // Address timing pulse
    input  wire logic                    memory_read_strobe_n,   // Read strobe, active low
    input  wire logic                    memory_write_strobe_n,  // Write strobe, active low
    input  wire logic                    run_utility_force,      // Relocate startup
    input  wire omad_pkg::omad_strap_t   ram_block_strap,        // RAM block selection
    input  wire omad_pkg::omad_strap_t   rom_pair_a_block_strap, // Pair A block selection
    input  wire omad_pkg::omad_strap_t   rom_pair_b_block_strap, // Pair B block selection
    input  wire omad_pkg::omad_rom_type_t rom_type_strap,        // Fitted ROM type
    output logic [7:0]                   mem_addr_hi,            // Latched, forced high byte
    output logic                         ram_cs,                 // RAM chip select
    output logic                         ram_oe,                 // RAM output enable
    output logic                         ram_we,                 // RAM write enable
    output omad_pkg::omad_sockets_t      rom_socket_cs,          // Socket chip selects
    output logic                         rom_oe,                 // ROM output enable
    output logic                         rom_shared_pin,         // A10 or control level
    output logic                         data_buffer_one_en,     // Buffer one enable
    output logic                         data_buffer_two_en,     // Buffer two enable
    output logic                         data_buffer_dir_read    // Buffers drive toward host
);
    import omad_pkg::*;

    // Whole registered state of the decoder
    typedef struct packed {
        logic          ram_cs;
        logic          ram_oe;
        logic          ram_we;
        omad_sockets_t socks;
        logic          rom_oe;
        logic          shared_pin;
        logic          buf_one;
        logic          buf_two;
        logic          dir_read;
    } omad_dec_st_t;

    omad_dec_st_t st_ff;         // Registered outputs
    omad_dec_st_t nxt_st;        // Next value
    logic [7:0]   hi_byte;       // From the latch

    // One-hot to index; flags a strap with not exactly one jumper
    function automatic logic [2:0] onehot_idx(input logic [3:0] v);
        logic [2:0] r;
        r = 3'h0;
        unique case (v)
            4'h1:    r = 3'h4;
            4'h2:    r = 3'h5;
            4'h4:    r = 3'h6;
            4'h8:    r = 3'h7;
            default: r = 3'h0; // Open or doubled jumpers
        endcase
        return r;
    endfunction : onehot_idx

    // Turn a strap into a 4-bit block number plus validity
    function automatic omad_block_t strap_decode(input omad_strap_t s);
        omad_block_t b;
        logic [2:0]  t;
        logic [2:0]  n;
        t       = onehot_idx(s.top);
        n       = onehot_idx(s.next);
        b.valid = t[2] && n[2]; // [RULE_13]
        b.block = {t[1:0], n[1:0]}; // [RULE_05]
        return b;
    endfunction : strap_decode

    // High byte capture and run-utility force
    omad_addr_latch u_latch (
        .clk                 (clk),
        .rstn                (rstn),
        .addr_bus            (addr_bus),
        .address_latch_pulse (address_latch_pulse),
        .run_utility_force   (run_utility_force),
        .hi_byte             (hi_byte)
    );

    // Decode from the captured byte
    always_comb begin
        omad_block_t   ram_b;
        omad_block_t   pa_b;
        omad_block_t   pb_b;
        logic [3:0]    blk;
        logic [1:0]    seg;
        logic          ram_hit;
        logic          pa_hit;
        logic          pb_hit;
        logic          is_2k;
        logic          any_rom;
        logic          any_sel;
        logic          rd;
        logic          wr;
        omad_sockets_t s;
        ram_b   = strap_decode(ram_block_strap);
        pa_b    = strap_decode(rom_pair_a_block_strap);
        pb_b    = strap_decode(rom_pair_b_block_strap);
        blk     = hi_byte[`OMAD_BLK_MSB:`OMAD_BLK_LSB];
        seg     = {hi_byte[`OMAD_A11_BIT], hi_byte[`OMAD_A10_BIT]};
        rd      = !memory_read_strobe_n;
        wr      = !memory_write_strobe_n;
        is_2k   = (rom_type_strap == OMAD_ROM_2K); // [RULE_12]
        // Block matches only for well-formed straps
        ram_hit = ram_b.valid && (blk == ram_b.block); // [RULE_03] [RULE_13]
        pa_hit  = pa_b.valid && (blk == pa_b.block); // [RULE_06]
        pb_hit  = pb_b.valid && (blk == pb_b.block); // [RULE_06]
        s       = '0;
        if (!is_2k && pa_hit && pb_hit) begin
            // Shared 1 KB block: one socket per segment
            unique case (seg)
                `OMAD_SEG_0: s.a_low  = 1'h1; // [RULE_08]
                `OMAD_SEG_1: s.b_low  = 1'h1; // [RULE_08]
                `OMAD_SEG_2: s.a_high = 1'h1; // [RULE_08]
                `OMAD_SEG_3: s.b_high = 1'h1; // [RULE_08]
            endcase
        end else begin
            // Halves by A11; A10 ignored so a 1 KB part wraps
            s.a_low  = pa_hit && !hi_byte[`OMAD_A11_BIT]; // [RULE_09] [RULE_10]
            s.a_high = pa_hit && hi_byte[`OMAD_A11_BIT]; // [RULE_09] [RULE_10]
            s.b_low  = pb_hit && !hi_byte[`OMAD_A11_BIT]; // [RULE_09] [RULE_10]
            s.b_high = pb_hit && hi_byte[`OMAD_A11_BIT]; // [RULE_09] [RULE_10]
        end
        // RAM owns its lowest segment over any overlaid socket
        if (ram_hit && (seg == `OMAD_SEG_0)) begin
            s = '0; // [RULE_07]
        end
        any_rom = |s;
        // RAM mirrors through its block where no socket answers
        nxt_st.ram_cs     = ram_hit && !any_rom; // [RULE_16] [RULE_07]
        nxt_st.socks      = s;
        // Output drivers only on a real read strobe
        nxt_st.ram_oe     = nxt_st.ram_cs && rd; // [RULE_15]
        nxt_st.ram_we     = nxt_st.ram_cs && wr;
        nxt_st.rom_oe     = any_rom && rd; // [RULE_15]
        // Shared pin carries A10 for 2 KB parts, a fixed level otherwise
        nxt_st.shared_pin = is_2k ? hi_byte[`OMAD_A10_BIT] : `OMAD_CTL_1K_LEVEL; // [RULE_12]
        // Whole RAM block and every socket claim the bus
        any_sel           = ram_hit || any_rom; // [RULE_04] [RULE_13]
        nxt_st.buf_one    = any_sel && (rd || wr);
        nxt_st.buf_two    = any_sel && (rd || wr);
        nxt_st.dir_read   = any_sel && rd; // [RULE_15]
    end

    // Output register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{ram_cs: `OMAD_SEL_RST, ram_oe: `OMAD_SEL_RST, ram_we: `OMAD_SEL_RST,
                       socks: '0, rom_oe: `OMAD_SEL_RST, shared_pin: `OMAD_SEL_RST,
                       buf_one: `OMAD_SEL_RST, buf_two: `OMAD_SEL_RST,
                       dir_read: `OMAD_SEL_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Ports straight from flip-flops
    assign mem_addr_hi          = hi_byte;
    assign ram_cs               = st_ff.ram_cs;
    assign ram_oe               = st_ff.ram_oe;
    assign ram_we               = st_ff.ram_we;
    assign rom_socket_cs        = st_ff.socks;
    assign rom_oe               = st_ff.rom_oe;
    assign rom_shared_pin       = st_ff.shared_pin;
    assign data_buffer_one_en   = st_ff.buf_one;
    assign data_buffer_two_en   = st_ff.buf_two;
    assign data_buffer_dir_read = st_ff.dir_read;

endmodule : omad_decoder
`default_nettype wire

/* dv/omad_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level relations of the decoder
module omad_decoder_properties (
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire logic [7:0]              addr_bus,
    input wire logic                    address_latch_pulse,
    input wire logic                    memory_read_strobe_n,
    input wire logic                    memory_write_strobe_n,
    input wire logic                    run_utility_force,
    input wire omad_pkg::omad_strap_t   ram_block_strap,
    input wire omad_pkg::omad_strap_t   rom_pair_a_block_strap,
    input wire logic [7:0]              mem_addr_hi,
    input wire logic                    ram_cs,
    input wire logic                    ram_oe,
    input wire omad_pkg::omad_sockets_t rom_socket_cs,
    input wire logic                    rom_oe,
    input wire logic                    data_buffer_one_en
);
    import omad_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Force held two edges sets the top bit
    property p_force; $past(rstn) && $past(run_utility_force, 2) && $past(run_utility_force) |-> mem_addr_hi[7];
    endproperty
    a_force: assert property (p_force) else $error("top bit not forced");
    // Byte shown with pulse high is held after pulse falls
    property p_cap; $past(rstn) && $past(rstn, 2) && $past(address_latch_pulse, 2) && !$past(address_latch_pulse)
        |-> mem_addr_hi[6:0] == $past(addr_bus[6:0], 2);
    endproperty
    a_cap: assert property (p_cap) else $error("high byte not captured");
    // No pulse fall, no change
    property p_hold; $past(rstn) && !$past(address_latch_pulse, 2) |-> $stable(mem_addr_hi[6:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("high byte changed");
    // RAM select only from a valid matching strap
    property p_ram; ram_cs |-> $past($onehot(ram_block_strap.top) && $onehot(ram_block_strap.next)
        && ram_block_strap.top[mem_addr_hi[7:6]] && ram_block_strap.next[mem_addr_hi[5:4]]);
    endproperty
    a_ram: assert property (p_ram) else $error("bad ram select");
    // Pair A sockets only inside pair A block
    property p_pair_a; rom_socket_cs.a_low || rom_socket_cs.a_high |-> $past(
        rom_pair_a_block_strap.top[mem_addr_hi[7:6]] && rom_pair_a_block_strap.next[mem_addr_hi[5:4]]);
    endproperty
    a_pair_a: assert property (p_pair_a) else $error("bad pair a select");
    // RAM and a socket never together
    property p_excl; ram_cs |-> rom_socket_cs == 4'h0;
    endproperty
    a_excl: assert property (p_excl) else $error("ram and socket both");
    // Output enables need the read strobe and a select
    property p_oe; ram_oe || rom_oe |-> !$past(memory_read_strobe_n) && (ram_cs || rom_socket_cs != 4'h0);
    endproperty
    a_oe: assert property (p_oe) else $error("enable without read");
    // Buffer one off without any strobe
    property p_buf; $past(memory_read_strobe_n) && $past(memory_write_strobe_n) |-> !data_buffer_one_en;
    endproperty
    a_buf: assert property (p_buf) else $error("buffers on idle");
endmodule : omad_decoder_properties
bind omad_decoder omad_decoder_properties u_props (.clk, .rstn, .addr_bus, .address_latch_pulse,
    .memory_read_strobe_n, .memory_write_strobe_n, .run_utility_force, .ram_block_strap,
    .rom_pair_a_block_strap, .mem_addr_hi, .ram_cs, .ram_oe, .rom_socket_cs, .rom_oe, .data_buffer_one_en);
`default_nettype wire

/* dv/omad_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Processor side: one eight-clock memory cycle per request
module omad_cpu_model (
    input  wire logic       clk,
    input  wire logic       go,        // Start one cycle
    input  wire logic [7:0] hi,        // High address byte
    input  wire logic       rd,        // Read when high
    output logic      [7:0] addr_bus = 8'h00, // Multiplexed address
    output logic            pulse = 1'h0,     // Address timing pulse
    output logic            rd_n = 1'h1,      // Read strobe
    output logic            wr_n = 1'h1,      // Write strobe
    output logic            busy       // Cycle running
);
    int   ph = 0;
    logic rd_ff = 1'h0;
    // Phase sequencer, moves after the falling edge
    always @(negedge clk) begin
        ph <= (ph != 0) ? (ph + 1) % 8 : int'(go);
        if (ph == 0)
            rd_ff <= rd;
        pulse <= (ph == 0) && go;
        addr_bus <= (ph == 0 && go) ? hi : ~addr_bus; // Low byte phase keeps changing
        // Strobes wait one cycle past the pulse fall so the new byte is latched first
        rd_n <= !(rd_ff && ph >= 2 && ph <= 5);
        wr_n <= !(!rd_ff && ph >= 2 && ph <= 5);
    end
    assign busy = (ph != 0);
endmodule : omad_cpu_model
`default_nettype wire

/* dv/omad_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module omad_decoder_bench;
    import omad_pkg::*;
    logic           clk = 1'h0, rstn = 1'h0, frc = 1'h0, go = 1'h0, rd = 1'h0, busy;
    logic [7:0]     hi = 8'h00, ab, mah;
    logic           lp, rdn, wrn, rcs, roe, rwe, rome, shp, b1, b2, dr;
    omad_strap_t    rs, pa, pb;
    omad_sockets_t  scs;
    omad_rom_type_t ty = OMAD_ROM_2K;
    int             err_total = 0, comparisons = 0;
    logic [7:0]     tv[8] = '{8'h20, 8'h24, 8'h90, 8'h94, 8'h98, 8'hC8, 8'h5C, 8'h3C};
    always #20 clk = ~clk;
    omad_cpu_model cpu (.clk(clk), .go(go), .hi(hi), .rd(rd), .addr_bus(ab), .pulse(lp), .rd_n(rdn),
        .wr_n(wrn), .busy(busy));
    omad_decoder uut (.clk(clk), .rstn(rstn), .addr_bus(ab), .address_latch_pulse(lp),
        .memory_read_strobe_n(rdn), .memory_write_strobe_n(wrn), .run_utility_force(frc),
        .ram_block_strap(rs), .rom_pair_a_block_strap(pa), .rom_pair_b_block_strap(pb), .rom_type_strap(ty),
        .mem_addr_hi(mah), .ram_cs(rcs), .ram_oe(roe), .ram_we(rwe), .rom_socket_cs(scs), .rom_oe(rome),
        .rom_shared_pin(shp), .data_buffer_one_en(b1), .data_buffer_two_en(b2), .data_buffer_dir_read(dr));
    // Strap for 4 KB block b
    function automatic omad_strap_t blk(logic [3:0] b);
        return {4'h1 << b[3:2], 4'h1 << b[1:0]};
    endfunction : blk
    function automatic logic hit(omad_strap_t t, logic [7:0] h);
        return $onehot(t.top) && $onehot(t.next) && t.top[h[7:6]] && t.next[h[5:4]];
    endfunction : hit
    // Expected selects and enables for one access
    function automatic logic [10:0] expv(logic [7:0] h, logic r);
        logic       rm, c, en;
        logic [3:0] s;
        rm = hit(rs, h);
        if (ty != OMAD_ROM_2K && hit(pa, h) && hit(pb, h))
            s = {h[3:2] == 2'h0, h[3:2] == 2'h2, h[3:2] == 2'h1, h[3:2] == 2'h3};
        else
            s = {hit(pa, h) & !h[3], hit(pa, h) & h[3], hit(pb, h) & !h[3], hit(pb, h) & h[3]};
        if (rm && h[3:2] == 2'h0)
            s = 4'h0;
        c = rm && s == 4'h0;
        en = rm || s != 4'h0;
        return {c, s, en, en, en & r, (s != 4'h0) & r, c & r, c & !r};
    endfunction : expv
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // One memory cycle, checked while its strobe is active
    task automatic acc(logic [7:0] h, logic r);
        logic [7:0] eh;
        eh = h | {frc, 7'h00};
        @(negedge clk);
        hi <= h;
        rd <= r;
        go <= 1'h1;
        @(negedge clk);
        go <= 1'h0;
        repeat (4) @(negedge clk);
        chk(mah, eh);
        chk({rcs, scs, b1, b2, dr, rome, roe, rwe}, expv(eh, r));
        chk(shp, (ty == OMAD_ROM_2K) ? eh[2] : 1'h1);
        for (int i = 0; i < 16 && busy; i++)
            @(negedge clk);
        chk({busy, b1, b2, rome, roe, rwe}, 6'h00);
        if (busy)
            print_verdict();
    endtask : acc
    initial begin
        rs = blk(4'h2);
        pa = blk(4'h9);
        pb = blk(4'hC);
        repeat (10) @(negedge clk);
        rstn <= 1'h1;
        foreach (tv[i])
            acc(tv[i], i[0]);
        pa = blk(4'h2);
        pb = blk(4'h2);
        for (int t = 0; t < 4; t++) begin
            ty = omad_rom_type_t'(t);
            for (int g = 0; g < 4; g++)
                acc(8'h20 | 8'(g << 2), 1'h1);
        end
        ty = OMAD_ROM_2K;
        rs = omad_strap_t'(8'h34);
        pa = blk(4'h9);
        pb = omad_strap_t'(8'h00);
        acc(8'h20, 1'h1);
        acc(8'hC8, 1'h0);
        frc = 1'h1;
        acc(8'h14, 1'h1);
        rstn <= 1'h0;
        @(negedge clk);
        chk({mah, rcs, scs, b1}, 14'h0000);
        rstn <= 1'h1;
        acc(8'h18, 1'h0);
        print_verdict();
    end
    // Guard against a hang
    initial begin
        repeat (5000) @(negedge clk);
        err_total++;
        print_verdict();
    end
endmodule : omad_decoder_bench
`default_nettype wire
